// ===== design/stepper_pkg.sv
// Purpose: Shared constants for the pulse-train stepper input link
// Assumes: One 200 MHz clock, active-low asynchronous reset
// Notes: Controller register map and device input slots
package stepper_pkg;
    // Device input slots, synchronised as one vector
    localparam int N_IN = 10;
    localparam int IX_CW = 0;
    localparam int IX_CCW = 1;
    localparam int IX_EXC = 2;
    localparam int IX_FREE = 3;
    localparam int IX_RSEL = 4;
    localparam int IX_RET = 5;
    localparam int IX_HOME = 6;
    localparam int IX_CLR = 7;
    localparam int IX_CCM = 8;
    localparam int IX_M0 = 9;
    // Resolutions in pulses per revolution
    localparam logic [13:0] PPR_LO_A = 14'd1000;
    localparam logic [13:0] PPR_HI_A = 14'd10000;
    localparam logic [13:0] PPR_LO_B = 14'd500;
    localparam logic [13:0] PPR_HI_B = 14'd5000;
    // Return-to-home step spacing, 10 us at 200 MHz
    localparam int CLK_MHZ = 200;
    localparam int RETURN_STEP_NS = 10000;
    localparam logic [15:0] RETURN_STEP_CYCLES = 16'(RETURN_STEP_NS * CLK_MHZ / 1000);
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    // Controller registers, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STEP = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_HALF = 4'hc;
    localparam int CTRL_DUAL = 0;
    localparam int CTRL_EXC = 1;
    localparam int CTRL_FREE = 2;
    localparam int CTRL_RSEL = 3;
    localparam int CTRL_RET = 4;
    localparam int CTRL_HOME = 5;
    localparam int CTRL_CLR = 6;
    localparam int CTRL_CCM = 7;
    localparam int CTRL_M0 = 8;
    localparam int STEP_DIR_BIT = 16;
    localparam logic [15:0] HALF_RESET = 16'h0064;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : stepper_pkg

// ===== design/stepper_if.sv
// Purpose: Opto-isolated input lines between controller and driver
// Assumes: All lines are levels, high means current flows
// Notes: Alarm line is the only return signal
`timescale 1ns/1ps
`default_nettype none
interface stepper_if;
    logic step_clockwise;
    logic step_counterclockwise;
    logic excite;
    logic free_run;
    logic res_select;
    logic return_home;
    logic home_zero;
    logic deviation_clear;
    logic current_regulation_mode;
    logic push_level_bit0;
    logic fault_ok_out;
    modport dev (
        input step_clockwise, step_counterclockwise, excite, free_run, res_select,
        input return_home, home_zero, deviation_clear, current_regulation_mode,
        input push_level_bit0,
        output fault_ok_out
    );
    modport ctl (
        output step_clockwise, step_counterclockwise, excite, free_run, res_select,
        output return_home, home_zero, deviation_clear, current_regulation_mode,
        output push_level_bit0,
        input fault_ok_out
    );
endinterface : stepper_if
`default_nettype wire

// ===== design/stepper_driver_input_control.sv
// Purpose: Driver end: decodes steps, keeps command position, modes
// Assumes: Switches and settings are static user-side levels
// Notes: Operation
// Operation
// - Step with direction on: one clockwise step
// - Step with direction off: one counterclockwise step
// - Dual mode: each line rise steps its way
// - Both dual lines on: no step accepted
// - Controller keeps pulse lines off when idle
// - Active excitation energises windings, sense configurable
// - Free-run cuts current, releases brake
// - Hold by excitation, brake, or released
// - Select input picks one of two resolutions
// - Third switch on ignores select input
// - Select rise with warning enabled blocks return; auto-return at free-run end still starts
// - Push mode repurposes three inputs
// - Push-current select switches to push current
// - Three push bits pick push current
// - Return moves until position is zero
// - Power-up position is zero
// - Home-zero rise clears position
// - Deviation clear ignores steps while on
// - Deviation clear aborts return operations
// - Alarm drops fault line, falling reset clears
// - Current mode honoured unless second switch on
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module stepper_driver_input_control (
    input wire logic CLK,
    input wire logic RST_N,
    stepper_if.dev LINK,
    input wire logic PULSE_MODE_DUAL,
    input wire logic EXCITE_NC,
    input wire logic SWITCH2,
    input wire logic SWITCH3,
    input wire logic SWITCH4,
    input wire logic PUSH_MODE,
    input wire logic WARN_ENABLE,
    input wire logic BRAKE_FITTED,
    input wire logic AUTO_RETURN,
    input wire logic FAULT_EVENT,
    input wire logic FAULT_RESETTABLE,
    output logic STEP_EVENT,
    output logic STEP_CW,
    output logic signed [31:0] POSITION,
    output logic RETURN_BUSY,
    output logic WINDING_ON,
    output logic BRAKE_RELEASE,
    output logic HOLD_BY_EXCITE,
    output logic HOLD_BY_BRAKE,
    output logic [13:0] RESOLUTION_PPR,
    output logic PUSH_CURRENT_ON,
    output logic [2:0] PUSH_LEVEL,
    output logic CURRENT_MODE,
    output logic DATA_WARNING
);
    typedef struct packed {
        logic [stepper_pkg::N_IN-1:0] s1;
        logic [stepper_pkg::N_IN-1:0] s2;
        logic [stepper_pkg::N_IN-1:0] s3;
        logic signed [31:0] pos;
        logic ret_busy;
        logic [15:0] ret_div;
        logic warn;
        logic fault;
        logic fatal;
        logic step_ev;
        logic step_cw;
        logic winding;
        logic brake_rel;
        logic hold_ex;
        logic hold_br;
        logic [13:0] ppr;
        logic push_on;
        logic [2:0] push_lvl;
        logic cur_mode;
    } state_t;

    state_t q;
    state_t d;
    logic [stepper_pkg::N_IN-1:0] pins;
    logic [stepper_pkg::N_IN-1:0] rise;
    logic [stepper_pkg::N_IN-1:0] fall;
    logic [stepper_pkg::N_IN-1:0] lvl;
    logic ext_cw;
    logic ext_ccw;
    logic ret_cw;
    logic ret_ccw;
    logic ret_start;
    logic excite_act;

    always_comb begin
        pins = '0;
        pins[stepper_pkg::IX_CW] = LINK.step_clockwise;
        pins[stepper_pkg::IX_CCW] = LINK.step_counterclockwise;
        pins[stepper_pkg::IX_EXC] = LINK.excite;
        pins[stepper_pkg::IX_FREE] = LINK.free_run;
        pins[stepper_pkg::IX_RSEL] = LINK.res_select;
        pins[stepper_pkg::IX_RET] = LINK.return_home;
        pins[stepper_pkg::IX_HOME] = LINK.home_zero;
        pins[stepper_pkg::IX_CLR] = LINK.deviation_clear;
        pins[stepper_pkg::IX_CCM] = LINK.current_regulation_mode;
        pins[stepper_pkg::IX_M0] = LINK.push_level_bit0;
    end

    // Edges from second and third stage only; first stage feeds nothing else
    assign lvl = q.s2;
    assign rise = q.s2 & ~q.s3;
    assign fall = ~q.s2 & q.s3;

    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        ext_cw = 1'b0;
        ext_ccw = 1'b0;
        ret_cw = 1'b0;
        ret_ccw = 1'b0;
        excite_act = lvl[stepper_pkg::IX_EXC] ^ EXCITE_NC;

        // Step decode; while the clear line is on pulses are dropped
        if (!lvl[stepper_pkg::IX_CLR] && !q.fault) begin
            if (PULSE_MODE_DUAL) begin
                // Both lines on means a wiring or timing fault, so no step
                ext_cw = rise[stepper_pkg::IX_CW] && !lvl[stepper_pkg::IX_CCW];
                ext_ccw = rise[stepper_pkg::IX_CCW] && !lvl[stepper_pkg::IX_CW];
            end else begin
                ext_cw = rise[stepper_pkg::IX_CW] && lvl[stepper_pkg::IX_CCW];
                ext_ccw = rise[stepper_pkg::IX_CW] && !lvl[stepper_pkg::IX_CCW];
            end
        end

        // Return to electrical home, also after free-run ends if enabled
        ret_start = !PUSH_MODE && !q.warn && rise[stepper_pkg::IX_RET];
        if (AUTO_RETURN && fall[stepper_pkg::IX_FREE]) begin
            ret_start = 1'b1;
        end
        if (q.ret_busy) begin
            if (q.pos == stepper_pkg::POS_RESET) begin
                d.ret_busy = 1'b0;
            end else if (q.ret_div == 16'h0000) begin
                d.ret_div = stepper_pkg::RETURN_STEP_CYCLES;
                ret_cw = q.pos < 0;
                ret_ccw = q.pos > 0;
            end else begin
                d.ret_div = q.ret_div - 16'h0001;
            end
        end else if (ret_start && !q.fault) begin
            d.ret_busy = 1'b1;
            d.ret_div = stepper_pkg::RETURN_STEP_CYCLES;
        end
        if (rise[stepper_pkg::IX_CLR] || q.fault) begin
            d.ret_busy = 1'b0;
        end

        // Command position; home-zero wins over a same-cycle step
        d.step_ev = ext_cw || ext_ccw || ret_cw || ret_ccw;
        if (d.step_ev) begin
            d.step_cw = ext_cw || ret_cw;
        end
        if (ext_cw || ret_cw) begin
            d.pos = q.pos + 32'sd1;
        end else if (ext_ccw || ret_ccw) begin
            d.pos = q.pos - 32'sd1;
        end
        if (!PUSH_MODE && rise[stepper_pkg::IX_HOME]) begin
            d.pos = stepper_pkg::POS_RESET;
            d.ret_busy = 1'b0;
        end

        // Abnormal-data warning; a new select rise beats the re-zero
        if (!PUSH_MODE && rise[stepper_pkg::IX_HOME]) begin
            d.warn = 1'b0;
        end
        if (WARN_ENABLE && !PUSH_MODE && rise[stepper_pkg::IX_RSEL]) begin
            d.warn = 1'b1;
        end

        // Faults; reset acts on the falling edge of the shared line
        if (fall[stepper_pkg::IX_CLR] && q.fault && !q.fatal) begin
            d.fault = 1'b0;
        end
        if (FAULT_EVENT) begin
            d.fault = 1'b1;
            d.fatal = q.fatal || !FAULT_RESETTABLE;
        end

        // Shaft holding; a fault cuts current and lets the brake hold
        d.winding = excite_act && !lvl[stepper_pkg::IX_FREE] && !d.fault;
        d.hold_ex = d.winding;
        d.hold_br = BRAKE_FITTED && !lvl[stepper_pkg::IX_FREE] && !d.winding;
        d.brake_rel = BRAKE_FITTED && !d.hold_br;

        // Resolution from switches and select input
        if (SWITCH3) begin
            d.ppr = SWITCH4 ? stepper_pkg::PPR_HI_B : stepper_pkg::PPR_HI_A;
        end else if (PUSH_MODE || !lvl[stepper_pkg::IX_RSEL]) begin
            d.ppr = SWITCH4 ? stepper_pkg::PPR_LO_B : stepper_pkg::PPR_LO_A;
        end else begin
            d.ppr = SWITCH4 ? stepper_pkg::PPR_HI_B : stepper_pkg::PPR_HI_A;
        end

        // Push-motion reuse of select, return and home-zero lines
        d.push_on = PUSH_MODE && lvl[stepper_pkg::IX_RSEL];
        if (PUSH_MODE) begin
            d.push_lvl = {lvl[stepper_pkg::IX_HOME], lvl[stepper_pkg::IX_RET],
                          lvl[stepper_pkg::IX_M0]};
        end else begin
            d.push_lvl = 3'h0;
        end
        d.cur_mode = lvl[stepper_pkg::IX_CCM] && !SWITCH2;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign LINK.fault_ok_out = !q.fault;
    assign STEP_EVENT = q.step_ev;
    assign STEP_CW = q.step_cw;
    assign POSITION = q.pos;
    assign RETURN_BUSY = q.ret_busy;
    assign WINDING_ON = q.winding;
    assign BRAKE_RELEASE = q.brake_rel;
    assign HOLD_BY_EXCITE = q.hold_ex;
    assign HOLD_BY_BRAKE = q.hold_br;
    assign RESOLUTION_PPR = q.ppr;
    assign PUSH_CURRENT_ON = q.push_on;
    assign PUSH_LEVEL = q.push_lvl;
    assign CURRENT_MODE = q.cur_mode;
    assign DATA_WARNING = q.warn;
endmodule : stepper_driver_input_control
`default_nettype wire

// ===== design/stepper_pulse_controller.sv
// Purpose: Controller end: AXI4-Lite registers drive step pulse train
// Assumes: Software sets levels in the control word
// Notes: A step command is refused while a train is running
`timescale 1ns/1ps
`default_nettype none
module stepper_pulse_controller (
    input wire logic CLK,
    input wire logic RST_N,
    stepper_if.ctl LINK,
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_HIGH = 4'b0100,
        ST_LOW = 4'b1000
    } pstate_t;

    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [15:0] half;
        logic [15:0] remain;
        logic dir;
        pstate_t st;
        logic [15:0] tmr;
        logic cw_o;
        logic ccw_o;
    } state_t;

    state_t q;
    state_t d;
    logic [31:0] wr_merge;
    logic busy;

    assign busy = q.st != ST_IDLE;
    assign AWREADY = !q.aw_ok && !q.bvalid;
    assign WREADY = !q.w_ok && !q.bvalid;
    assign ARREADY = !q.rvalid;

    always_comb begin
        d = q;
        wr_merge = 32'h0000_0000;
        if (AWVALID && AWREADY) begin
            d.aw_ok = 1'b1;
            d.awaddr = AWADDR;
        end
        if (WVALID && WREADY) begin
            d.w_ok = 1'b1;
            d.wdata = WDATA;
            d.wstrb = WSTRB;
        end
        if (BVALID && BREADY) begin
            d.bvalid = 1'b0;
        end
        if (RVALID && RREADY) begin
            d.rvalid = 1'b0;
        end

        // Write commits once address and data are both held
        if (q.aw_ok && q.w_ok) begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = stepper_pkg::RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
                wr_merge[b*8 +: 8] = q.wstrb[b] ? q.wdata[b*8 +: 8] : q.ctrl[b*8 +: 8];
            end
            case (q.awaddr)
                stepper_pkg::REG_CTRL: d.ctrl = wr_merge;
                stepper_pkg::REG_STEP: begin
                    if (!busy && q.wstrb[1:0] == 2'b11) begin
                        d.remain = q.wdata[15:0];
                        d.dir = q.wdata[stepper_pkg::STEP_DIR_BIT];
                    end
                end
                stepper_pkg::REG_HALF: begin
                    if (q.wstrb[1:0] == 2'b11 && q.wdata[15:0] != 16'h0000) begin
                        d.half = q.wdata[15:0];
                    end
                end
                stepper_pkg::REG_STATUS: d.bresp = stepper_pkg::RESP_OKAY;
                default: d.bresp = stepper_pkg::RESP_SLVERR;
            endcase
        end

        if (ARVALID && ARREADY) begin
            d.rvalid = 1'b1;
            d.rresp = stepper_pkg::RESP_OKAY;
            case (ARADDR)
                stepper_pkg::REG_CTRL: d.rdata = q.ctrl;
                stepper_pkg::REG_STEP: d.rdata = {15'h0000, q.dir, q.remain};
                stepper_pkg::REG_STATUS: d.rdata = {14'h0000, LINK.fault_ok_out, busy, q.remain};
                stepper_pkg::REG_HALF: d.rdata = {16'h0000, q.half};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = stepper_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Pulse train; the unused line stays off so no step is lost
        case (q.st)
            ST_IDLE: begin
                d.cw_o = 1'b0;
                d.ccw_o = 1'b0;
                if (q.remain != 16'h0000) begin
                    d.ccw_o = !q.ctrl[stepper_pkg::CTRL_DUAL] && q.dir;
                    d.tmr = q.half;
                    d.st = ST_SETUP;
                end
            end
            ST_SETUP, ST_LOW: begin
                if (q.tmr > 16'h0001) begin
                    d.tmr = q.tmr - 16'h0001;
                end else if (q.remain == 16'h0000) begin
                    d.ccw_o = 1'b0;
                    d.st = ST_IDLE;
                end else begin
                    d.tmr = q.half;
                    d.st = ST_HIGH;
                    if (q.ctrl[stepper_pkg::CTRL_DUAL]) begin
                        d.cw_o = q.dir;
                        d.ccw_o = !q.dir;
                    end else begin
                        d.cw_o = 1'b1;
                    end
                end
            end
            ST_HIGH: begin
                if (q.tmr > 16'h0001) begin
                    d.tmr = q.tmr - 16'h0001;
                end else begin
                    d.cw_o = 1'b0;
                    d.ccw_o = q.ctrl[stepper_pkg::CTRL_DUAL] ? 1'b0 : q.dir;
                    d.remain = q.remain - 16'h0001;
                    d.tmr = q.half;
                    d.st = ST_LOW;
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.half <= stepper_pkg::HALF_RESET;
        end else begin
            q <= d;
        end
    end

    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign RVALID = q.rvalid;
    assign RRESP = q.rresp;
    assign RDATA = q.rdata;
    assign LINK.step_clockwise = q.cw_o;
    assign LINK.step_counterclockwise = q.ccw_o;
    // Level lines straight from the control word; the position-sensitive
    // ones (home-zero, current mode) are software's to change only at rest
    assign LINK.excite = q.ctrl[stepper_pkg::CTRL_EXC];
    assign LINK.free_run = q.ctrl[stepper_pkg::CTRL_FREE];
    assign LINK.res_select = q.ctrl[stepper_pkg::CTRL_RSEL];
    assign LINK.return_home = q.ctrl[stepper_pkg::CTRL_RET];
    assign LINK.home_zero = q.ctrl[stepper_pkg::CTRL_HOME];
    assign LINK.deviation_clear = q.ctrl[stepper_pkg::CTRL_CLR];
    assign LINK.current_regulation_mode = q.ctrl[stepper_pkg::CTRL_CCM];
    assign LINK.push_level_bit0 = q.ctrl[stepper_pkg::CTRL_M0];
endmodule : stepper_pulse_controller
`default_nettype wire

// ===== verification/stepper_link_props.sv
// Purpose: Link-level checks between pulse controller and driver
// Assumes: Half period programmed to 3 cycles or more
// Notes: Sees only the link lines, so mode-specific rules stay loose
`timescale 1ns/1ps
`default_nettype none
module stepper_link_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic step_clockwise,
    input wire logic step_counterclockwise,
    input wire logic deviation_clear,
    input wire logic fault_ok_out
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_cw_high;
        step_clockwise[*3];
    endsequence
    sequence s_cw_low;
        !step_clockwise[*3];
    endsequence
    sequence s_clr_held;
        deviation_clear[*4];
    endsequence
    a_cw_high_width: assert property ($rose(step_clockwise) |-> s_cw_high)
        else $error("clockwise line high too briefly");
    a_cw_low_width: assert property ($fell(step_clockwise) |-> s_cw_low)
        else $error("clockwise line low too briefly");
    a_ccw_high_width: assert property ($rose(step_counterclockwise) |-> step_counterclockwise[*3])
        else $error("counterclockwise line high too briefly");
    a_dir_before_step: assert property ($rose(step_clockwise) |-> $stable(step_counterclockwise))
        else $error("direction moved with the step edge");
    a_ccw_rise_alone: assert property ($rose(step_counterclockwise) |-> !step_clockwise)
        else $error("second line rose while first was on");
    a_ccw_fall_alone: assert property ($fell(step_counterclockwise) |-> !step_clockwise)
        else $error("second line fell while first was on");
    a_fault_stays_low: assert property (s_clr_held ##0 !fault_ok_out |=> !fault_ok_out)
        else $error("fault line recovered while reset held on");
    a_fault_rise_cause: assert property ($rose(fault_ok_out) |-> $past(deviation_clear, 4) && !$past(deviation_clear, 3))
        else $error("fault line recovered without falling reset");
endmodule : stepper_link_props
`default_nettype wire

// ===== verification/test_stepper_driver_input_control.sv
// Purpose: Drives controller over AXI4-Lite, checks driver outputs
// Assumes: Half period set to 4 cycles to keep trains short
// Notes: Return steps are slow, so positions are kept small
`timescale 1ns/1ps
`default_nettype none
module test_stepper_driver_input_control;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hf;
    logic [31:0] WDATA = 32'h0, RDATA, ctrl = 32'h0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    logic dual = 0, sw2 = 0, sw3 = 0, sw4 = 0, push = 0, warn = 0, brake = 0, fev = 0, fres = 0, nc = 0;
    logic step_ev, step_cw, ret_busy, wind, brel, hexc, hbrk, pcur, cmode, dwarn;
    logic signed [31:0] pos;
    logic [13:0] ppr;
    logic [2:0] plev;
    int mismatches = 0, compares = 0, pos_m = 0, ev_n = 0, ev_m = 0;
    stepper_if lnk();
    always #2.5 CLK = ~CLK;
    stepper_pulse_controller stepper_pulse_controller_inst (.CLK(CLK), .RST_N(RST_N),
        .LINK(lnk.ctl), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    stepper_driver_input_control stepper_driver_input_control_inst (.CLK(CLK), .RST_N(RST_N),
        .LINK(lnk.dev), .PULSE_MODE_DUAL(dual), .EXCITE_NC(nc), .SWITCH2(sw2), .SWITCH3(sw3),
        .SWITCH4(sw4), .PUSH_MODE(push), .WARN_ENABLE(warn), .BRAKE_FITTED(brake),
        .AUTO_RETURN(1'b0), .FAULT_EVENT(fev), .FAULT_RESETTABLE(fres), .STEP_EVENT(step_ev),
        .STEP_CW(step_cw), .POSITION(pos), .RETURN_BUSY(ret_busy), .WINDING_ON(wind),
        .BRAKE_RELEASE(brel), .HOLD_BY_EXCITE(hexc), .HOLD_BY_BRAKE(hbrk),
        .RESOLUTION_PPR(ppr), .PUSH_CURRENT_ON(pcur), .PUSH_LEVEL(plev),
        .CURRENT_MODE(cmode), .DATA_WARNING(dwarn));
    stepper_link_props props_inst (.CLK(CLK), .RST_N(RST_N),
        .step_clockwise(lnk.step_clockwise), .step_counterclockwise(lnk.step_counterclockwise),
        .deviation_clear(lnk.deviation_clear), .fault_ok_out(lnk.fault_ok_out));
    always @(posedge CLK) begin
        if (step_ev === 1'b1) ev_n <= ev_n + 1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID === 1'b1) break;
        end
        BREADY <= 1'b0;
    endtask : axw
    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID === 1'b1) break;
        end
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask : axr
    task automatic setc(input logic [31:0] v);
        axw(stepper_pkg::REG_CTRL, v);
        ctrl = v;
        dual <= v[0];
        repeat (6) @(posedge CLK);
    endtask : setc
    // Waits on the busy flag, not on a cycle count
    task automatic steps(input bit cw, input int n);
        logic [31:0] d;
        logic [1:0] r;
        axw(stepper_pkg::REG_STEP, {15'h0, cw, 16'(n)});
        for (int k = 0; k < 400; k++) begin
            axr(stepper_pkg::REG_STATUS, d, r);
            if (d[16] === 1'b0) break;
        end
        repeat (8) @(posedge CLK);
        if (!ctrl[6]) begin
            pos_m += cw ? n : -n;
            ev_m += n;
        end
    endtask : steps
    task automatic done(input string s);
        $display("test %s done, compares=%0d", s, compares);
    endtask : done
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int e;
        void'($urandom(63806));
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        chk(pos, 0);
        chk(lnk.fault_ok_out, 1);
        axw(stepper_pkg::REG_HALF, 32'h4);
        setc(32'h2);
        steps(1, 1 + $urandom % 4);
        chk(pos, pos_m);
        chk(step_cw, 1);
        steps(0, 1 + $urandom % 5);
        chk(pos, pos_m);
        chk(step_cw, 0);
        setc(32'h3);
        steps(1, 1 + $urandom % 3);
        steps(0, 1 + $urandom % 4);
        chk(pos, pos_m);
        // Single-mode train seen in dual mode: direction rise steps, pulses refused
        setc(32'h2);
        dual <= 1'b1;
        axw(stepper_pkg::REG_STEP, 32'h0001_0002);
        repeat (40) @(posedge CLK);
        pos_m--;
        ev_m++;
        chk(pos, pos_m);
        setc(32'h43);
        steps(1, 2);
        chk(pos, pos_m);
        chk(ev_n, ev_m);
        done("steps");
        setc(32'h3);
        steps(1, 9);
        ev_m += pos_m < 0 ? -pos_m : pos_m;
        setc(32'h13);
        chk(ret_busy, 1);
        setc(32'h53);
        chk(ret_busy, 0);
        setc(32'h3);
        setc(32'h13);
        for (int k = 0; k < 30000; k++) begin
            @(posedge CLK);
            if (ret_busy !== 1'b1) break;
        end
        repeat (6) @(posedge CLK);
        pos_m = 0;
        chk(pos, 0);
        chk(ev_n, ev_m);
        done("return");
        warn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            sw3 <= i[2];
            sw4 <= i[1];
            setc(i[0] ? 32'hb : 32'h3);
            e = i[1] ? ((i[2] | i[0]) ? 5000 : 500) : ((i[2] | i[0]) ? 10000 : 1000);
            chk(ppr, e);
        end
        chk(dwarn, 1);
        steps(1, 2);
        setc(32'h1b);
        repeat (50) @(posedge CLK);
        chk(pos, pos_m);
        chk(ret_busy, 0);
        setc(32'h23);
        setc(32'h3);
        pos_m = 0;
        chk(pos, 0);
        chk(dwarn, 0);
        warn <= 1'b0;
        done("resolution");
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            brake <= i[2];
            setc(32'h1 | (i[1] << 1) | (i[0] << 2));
            chk(hexc, i[1] & !i[0]);
            chk(hbrk, i[2] & !i[1] & !i[0]);
            chk(wind, i[1] & !i[0]);
            chk(brel, i[2] & (i[1] | i[0]));
        end
        nc <= 1'b1;
        setc(32'h1);
        chk(wind, 1);
        nc <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            sw2 <= i[1];
            setc(32'h3 | (i[0] << 7));
            chk(cmode, i[0] & !i[1]);
        end
        done("levels");
        steps(1, 2);
        push <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            setc(32'h3 | (i[0] << 3) | (i[1] << 4) | (i[2] << 5) | (i[3] << 8));
            chk(pcur, i[0]);
            chk(plev, {i[2], i[1], i[3]});
        end
        setc(32'h3);
        push <= 1'b0;
        chk(pos, pos_m);
        chk(ret_busy, 0);
        done("push");
        @(posedge CLK);
        fres <= 1'b1;
        fev <= 1'b1;
        @(posedge CLK);
        fev <= 1'b0;
        repeat (6) @(posedge CLK);
        chk(lnk.fault_ok_out, 0);
        setc(32'h43);
        chk(lnk.fault_ok_out, 0);
        setc(32'h3);
        chk(lnk.fault_ok_out, 1);
        axr(4'h2, d, r);
        chk(r, stepper_pkg::RESP_SLVERR);
        done("fault");
        tally_and_finish();
    end
endmodule : test_stepper_driver_input_control
`default_nettype wire
